// >>> rtl/power_module_telemetry_i2c_slave.v
// Purpose: Two-wire bus target returning telemetry bytes by data pointer
// Assumes: Bus lines sampled synchronously to mclk, filtered upstream
// Notes: Target only; open-drain data driven through an output enable
`timescale 1ns/1ps
`include "telemetry_defines.vh"

module power_module_telemetry_i2c_slave #(
    parameter DATA_W = 8
) (
    input wire mclk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    output reg scl_out,
    output reg scl_oe,
    input wire [2:0] addr_strap,
    input wire feed_a_enable_flag,
    input wire feed_b_enable_flag,
    input wire input_fault_flag,
    input wire holdup_connected_flag,
    input wire switch_on_flag,
    input wire output_above_uv_flag,
    input wire [DATA_W-1:0] holdup_cap_voltage,
    input wire [DATA_W-1:0] output_current,
    input wire [DATA_W-1:0] feed_a_voltage,
    input wire [DATA_W-1:0] feed_b_voltage,
    input wire [DATA_W-1:0] module_temperature,
    output reg [DATA_W-1:0] pointer_out,
    output reg busy
);

    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_ADDR = 6'h02;
    localparam [5:0] S_ACK = 6'h04;
    localparam [5:0] S_PTR = 6'h08;
    localparam [5:0] S_SEND = 6'h10;
    localparam [5:0] S_MACK = 6'h20;

    reg [5:0] state_reg;
    reg [5:0] ack_ret_reg;
    reg scl_d_reg;
    reg sda_d_reg;
    reg [2:0] cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] ptr_reg;
    reg [7:0] tx_reg;
    reg [2:0] addr_low_reg;
    reg [7:0] rd_byte;
    reg [7:0] status_byte;

    wire scl_rise = scl_in & ~scl_d_reg;
    wire scl_fall = ~scl_in & scl_d_reg;
    wire start_cond = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
    wire stop_cond = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
    wire [7:0] rx_byte = {shift_reg[6:0], sda_in};
    // Counter wraps to zero after the eighth rising edge
    wire byte_end = scl_fall & (cnt_reg == `BIT_CNT_ZERO);
    wire last_bit = (cnt_reg == `BIT_CNT_LAST);
    wire byte_seen = (shift_reg != `BYTE_ZERO);
    wire addr_match = (shift_reg[7:4] == `ADDR_FIXED_NIBBLE) & (shift_reg[3:1] == addr_low_reg);
    wire [2:0] cnt_inc = cnt_reg + `BIT_CNT_STEP;
    reg [5:0] state_next;
    reg [5:0] ack_ret_next;
    reg [2:0] cnt_next;
    reg [7:0] shift_next;
    reg [7:0] ptr_next;
    reg [7:0] tx_next;
    reg sda_oe_next;

    // Strap caught after reset release, not under reset
    always @(posedge mclk) begin
        if (rst) begin
            addr_low_reg <= `STRAP_RESET;
        end else if (state_reg == S_IDLE) begin
            addr_low_reg <= addr_strap;
        end
    end

    always @* begin
        status_byte = `BYTE_ZERO;
        status_byte[`ST_BIT_FEED_A] = feed_a_enable_flag;
        status_byte[`ST_BIT_FEED_B] = feed_b_enable_flag;
        status_byte[`ST_BIT_FAULT] = input_fault_flag;
        status_byte[`ST_BIT_RSVD3] = 1'b0;
        status_byte[`ST_BIT_HOLDUP] = holdup_connected_flag;
        status_byte[`ST_BIT_SWITCH] = switch_on_flag;
        status_byte[`ST_BIT_OUT_UV] = output_above_uv_flag;
        status_byte[`ST_BIT_RSVD7] = 1'b0;
    end

    always @* begin
        case (ptr_reg)
            `PTR_STATUS: rd_byte = status_byte;
            `PTR_HOLDUP_V: rd_byte = holdup_cap_voltage;
            `PTR_OUT_CURRENT: rd_byte = output_current;
            `PTR_FEED_A_V: rd_byte = feed_a_voltage;
            `PTR_FEED_B_V: rd_byte = feed_b_voltage;
            `PTR_TEMPERATURE: rd_byte = module_temperature;
            default: rd_byte = `BYTE_ZERO;
        endcase
    end

    // Next-state decode; the state, counter, shift, pointer, transmit and data enable registers only load these
    always @* begin
        state_next = state_reg;
        ack_ret_next = ack_ret_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        tx_next = tx_reg;
        sda_oe_next = sda_oe;
        if (stop_cond) begin
            state_next = S_IDLE;
            sda_oe_next = 1'b0;
        end else if (start_cond) begin
            // Repeated start keeps the pointer for the read phase
            state_next = S_ADDR;
            cnt_next = `BIT_CNT_ZERO;
            // Stale bits of an ignored address would fake a byte end
            shift_next = `BYTE_ZERO;
            sda_oe_next = 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    sda_oe_next = 1'b0;
                end
                S_ADDR: begin
                    if (scl_rise) begin
                        shift_next = rx_byte;
                        cnt_next = cnt_inc;
                    end
                    if (byte_end && addr_match) begin
                        state_next = S_ACK;
                        sda_oe_next = 1'b1;
                        tx_next = rd_byte;
                        ack_ret_next = shift_reg[0] ? S_SEND : S_PTR;
                    end else if (byte_end && byte_seen) begin
                        // Not for us: stay off the bus till next start
                        state_next = S_IDLE;
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        state_next = ack_ret_reg;
                        cnt_next = `BIT_CNT_ZERO;
                        shift_next = `BYTE_ZERO;
                        if (ack_ret_reg == S_SEND) begin
                            sda_oe_next = ~tx_reg[7];
                            tx_next = {tx_reg[6:0], 1'b0};
                        end else begin
                            sda_oe_next = 1'b0;
                        end
                    end
                end
                S_PTR: begin
                    if (scl_rise) begin
                        shift_next = rx_byte;
                        cnt_next = cnt_inc;
                        if (last_bit) begin
                            ptr_next = rx_byte;
                        end
                    end
                    if (byte_end && byte_seen) begin
                        state_next = S_ACK;
                        ack_ret_next = S_PTR;
                        sda_oe_next = 1'b1;
                    end
                end
                S_SEND: begin
                    if (scl_rise) begin
                        cnt_next = cnt_inc;
                    end
                    if (byte_end) begin
                        state_next = S_MACK;
                        sda_oe_next = 1'b0;
                    end else if (scl_fall) begin
                        sda_oe_next = ~tx_reg[7];
                        tx_next = {tx_reg[6:0], 1'b0};
                    end
                end
                S_MACK: begin
                    // Master ack asks for more; resend same pointer
                    if (scl_rise) begin
                        if (sda_in) begin
                            state_next = S_IDLE;
                        end else begin
                            state_next = S_ACK;
                            ack_ret_next = S_SEND;
                            tx_next = rd_byte;
                        end
                    end
                end
                default: begin
                    state_next = S_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
    end

    // Line samplers preset high: no false edge after reset
    always @(posedge mclk) begin
        if (rst) begin
            scl_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_in;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            sda_d_reg <= 1'b1;
        end else begin
            sda_d_reg <= sda_in;
        end
    end

    // One-hot state; default branch recovers a stray code
    always @(posedge mclk) begin
        if (rst) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            ack_ret_reg <= S_IDLE;
        end else begin
            ack_ret_reg <= ack_ret_next;
        end
    end

    // Bit counter wraps on its own after eight edges
    always @(posedge mclk) begin
        if (rst) begin
            cnt_reg <= `BIT_CNT_ZERO;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            shift_reg <= `BYTE_ZERO;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // Pointer survives stops; only reset clears it
    always @(posedge mclk) begin
        if (rst) begin
            ptr_reg <= `PTR_RESET;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    // Transmit byte shifts out MSB first
    always @(posedge mclk) begin
        if (rst) begin
            tx_reg <= `BYTE_ZERO;
        end else begin
            tx_reg <= tx_next;
        end
    end

    // Open drain: level fixed low, only the enable moves
    always @(posedge mclk) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= sda_oe_next;
        end
    end

    // Master owns the clock; both pins stay released
    always @(posedge mclk) begin
        if (rst) begin
            scl_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            scl_oe <= 1'b0;
        end else begin
            scl_oe <= 1'b0;
        end
    end

    // Mirrors lag the state by one cycle
    always @(posedge mclk) begin
        if (rst) begin
            pointer_out <= `PTR_RESET;
        end else begin
            pointer_out <= ptr_reg;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_reg != S_IDLE);
        end
    end

endmodule

// >>> rtl/telemetry_defines.vh
// Purpose: Constants for the power module telemetry two-wire target
// Assumes: Included by the telemetry target only
// Notes: Pointer values and status bit positions of the read map
`ifndef TELEMETRY_DEFINES_VH
`define TELEMETRY_DEFINES_VH
`define ADDR_FIXED_NIBBLE 4'h5
`define PTR_STATUS 8'h1e
`define PTR_HOLDUP_V 8'h1f
`define PTR_OUT_CURRENT 8'h21
`define PTR_FEED_A_V 8'h22
`define PTR_FEED_B_V 8'h23
`define PTR_TEMPERATURE 8'h28
`define PTR_RESET 8'h00
`define BYTE_ZERO 8'h00
`define ST_BIT_FEED_A 0
`define ST_BIT_FEED_B 1
`define ST_BIT_FAULT 2
`define ST_BIT_RSVD3 3
`define ST_BIT_HOLDUP 4
`define ST_BIT_SWITCH 5
`define ST_BIT_OUT_UV 6
`define ST_BIT_RSVD7 7
`define BIT_CNT_LAST 3'h7
`define BIT_CNT_ZERO 3'h0
`define BIT_CNT_STEP 3'h1
`define STRAP_RESET 3'h7
`endif

// >>> testbench/i2c_master_model.sv
// Purpose: Bus master reading one or two bytes by pointer
// Assumes: Pulled-up lines; a 1 on a drive releases it
// Notes: Clock high 5 mclk and low 7 mclk per bit, above the 4 mclk minimum
`timescale 1ns/1ps
module i2c_master_model (
    input wire mclk,
    input wire sda_line,
    output reg scl_drv = 1'b1,
    output reg sda_drv = 1'b1
);
    task lines(input c, input s, input integer n);
        scl_drv = c;
        sda_drv = s;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task byte_x(input [8:0] b, output [8:0] r);
        integer i;
        for (i = 8; i >= 0; i = i - 1) begin
            lines(0, b[i], 5);
            lines(1, b[i], 3);
            r[i] = sda_line;
            lines(1, b[i], 2);
            lines(0, b[i], 2);
        end
    endtask
    task xfer(input [6:0] a, input [7:0] p, input twice, output [7:0] d, output [7:0] d2,
        output ok);
        reg [8:0] x0, x1, x2, x3, x4;
        lines(1, 0, 5);
        lines(0, 0, 2);
        byte_x({a, 2'b01}, x0);
        byte_x({p, 1'b1}, x1);
        lines(0, 1, 3);
        lines(1, 1, 5);
        lines(1, 0, 5);
        lines(0, 0, 2);
        byte_x({a, 2'b11}, x2);
        byte_x({8'hff, ~twice}, x3);
        x4 = 9'h1ff;
        if (twice)
            byte_x(9'h1ff, x4);
        lines(0, 0, 3);
        lines(1, 0, 5);
        lines(1, 1, 5);
        d = x3[8:1];
        d2 = x4[8:1];
        ok = !x0[0] && !x1[0] && !x2[0];
    endtask
endmodule

// >>> testbench/power_module_telemetry_i2c_slave_tb.sv
// Purpose: Reads each pointer under varied straps and flags
// Assumes: Analog counts tied to fixed distinct values
// Notes: Each row also tries a wrong address, which must be ignored
`timescale 1ns/1ps
module power_module_telemetry_i2c_slave_tb;
    reg mclk = 1'b0, rst = 1'b1, ok;
    reg [2:0] strap = 3'h0;
    reg [5:0] flags = 6'h00;
    reg [7:0] d, d2;
    wire [7:0] ptr_w;
    wire busy_w;
    wire scl_drv, sda_drv, sda_out, sda_oe, scl_out, scl_oe;
    wire sda_line = sda_drv & ~(sda_oe & ~sda_out);
    wire scl_line = scl_drv & ~(scl_oe & ~scl_out);
    integer n_errors = 0, tests_run = 0, i;
    reg [21:0] rows [0:9] = '{{8'h1e,6'h2a,8'h52}, {8'h1e,6'h15,8'h25}, {8'h1e,6'h3f,8'h77},
        {8'h1f,6'h00,8'ha5}, {8'h21,6'h00,8'h3c}, {8'h22,6'h00,8'hc3}, {8'h23,6'h00,8'h5a},
        {8'h28,6'h00,8'h81}, {8'h20,6'h3f,8'h00}, {8'h30,6'h3f,8'h00}};
    i2c_master_model bus (.mclk(mclk), .sda_line(sda_line), .scl_drv(scl_drv),
        .sda_drv(sda_drv));
    power_module_telemetry_i2c_slave dut (.mclk(mclk), .rst(rst), .scl_in(scl_line),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
        .scl_oe(scl_oe), .addr_strap(strap), .feed_a_enable_flag(flags[0]),
        .feed_b_enable_flag(flags[1]), .input_fault_flag(flags[2]),
        .holdup_connected_flag(flags[3]), .switch_on_flag(flags[4]),
        .output_above_uv_flag(flags[5]), .holdup_cap_voltage(8'ha5), .output_current(8'h3c),
        .feed_a_voltage(8'hc3), .feed_b_voltage(8'h5a), .module_temperature(8'h81),
        .pointer_out(ptr_w), .busy(busy_w));
    initial forever #4 mclk = ~mclk;
    task chk(input [8:0] got, input [8:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge mclk);
        n_errors = n_errors + 1;
        close_out;
    end
    initial begin
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        bus.lines(1, 1, 4);
        for (i = 0; i < 10; i = i + 1) begin
            strap = i[2:0];
            flags = rows[i][13:8];
            bus.xfer({4'h5, strap}, rows[i][21:14], 1'b0, d, d2, ok);
            chk({ok, d}, {1'b1, rows[i][7:0]});
            bus.xfer({i[0] ? 4'hd : 4'h5, ~strap}, 8'h28, 1'b0, d, d2, ok);
            chk({ok, d}, 9'h0ff);
            $display("row %0d done", i);
        end
        // Master ack must bring the same byte again
        strap = 3'h2;
        flags = 6'h3f;
        bus.xfer({4'h5, strap}, 8'h1e, 1'b1, d, d2, ok);
        chk({ok, d}, {1'b1, 8'h77});
        chk({1'b0, d2}, {1'b0, 8'h77});
        chk({1'b0, ptr_w}, {1'b0, 8'h1e});
        chk({8'h00, busy_w}, 9'h000);
        $display("repeat read done");
        // Start cut short by a stop must leave the target idle
        bus.lines(1, 0, 5);
        chk({8'h00, busy_w}, 9'h001);
        bus.lines(1, 1, 5);
        chk({8'h00, busy_w}, 9'h000);
        bus.xfer({4'h5, strap}, 8'h21, 1'b0, d, d2, ok);
        chk({ok, d}, {1'b1, 8'h3c});
        $display("cut frame done");
        rst = 1'b1;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        bus.lines(1, 1, 4);
        chk({1'b0, ptr_w}, {1'b0, 8'h00});
        chk({8'h00, busy_w}, 9'h000);
        bus.xfer({4'h5, strap}, 8'h1f, 1'b0, d, d2, ok);
        chk({ok, d}, {1'b1, 8'ha5});
        $display("mid-run reset done");
        close_out;
    end
endmodule

// >>> testbench/telemetry_checker_properties.sv
// Purpose: Bus, pointer and busy checks of the telemetry target
// Assumes: One mclk domain, rst sync high
// Notes: Ports packed per line to keep it short
`timescale 1ns/1ps
module telemetry_checker #(parameter DATA_W = 8) (
    input wire mclk, rst, scl_in, sda_in, sda_out, sda_oe, scl_out, scl_oe, busy,
    input wire [DATA_W-1:0] pointer_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_no_clock: assert property (!scl_oe && !scl_out) else $error("clock driven");
    a_low_only: assert property (sda_oe |-> !sda_out) else $error("data high");
    a_idle_free: assert property (!busy |-> !sda_oe) else $error("idle drive");
    a_bit_stands: assert property ($rose(sda_oe) |-> sda_oe [*4]) else $error("short bit");
    a_moves_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("bad edge");
    a_stop_ends: assert property (scl_in && $rose(sda_in) |-> ##[1:6] !busy)
        else $error("stop ignored");
    a_ptr_held: assert property (!busy && !$past(busy) |-> $stable(pointer_out))
        else $error("pointer moved");
    a_reset_clean: assert property ($fell(rst) |-> !busy && !sda_oe && !pointer_out)
        else $error("reset state");
endmodule
bind power_module_telemetry_i2c_slave telemetry_checker #(.DATA_W(DATA_W)) u_chk (.mclk(mclk),
    .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_out(scl_out), .scl_oe(scl_oe), .busy(busy), .pointer_out(pointer_out));
